/* hw/gpib_ctrl.sv */
// gpib controller function with apb register access
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module gpib_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [gpib_ctrl_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire gpib_ctrl_pkg::gpib_lines_t bus_in,
	output gpib_ctrl_pkg::gpib_lines_t bus_out,
	output gpib_ctrl_pkg::gpib_lines_t bus_oe,
	output logic sc_drive
);
	gpib_ctrl_pkg::st_t q;
	gpib_ctrl_pkg::st_t n;
	gpib_ctrl_pkg::gpib_lines_t asn;
	gpib_ctrl_pkg::aux_cmd_t aux;
	gpib_ctrl_pkg::interrupt_status_one_t set1;
	gpib_ctrl_pkg::interrupt_status_two_t set2;
	logic setup;
	logic access;
	logic wr;
	logic aux_wr;
	logic rd_one;
	logic rd_two;
	logic acc;
	logic src_done;
	logic cmd_v;
	logic cont_on;
	logic listen;
	logic [7:0] cmd_b;

	// asserted levels of the synchronised lines
	assign asn = gpib_ctrl_pkg::gpib_lines_t'(~q.s2);
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wr = access && pwrite && !q.slverr;
	assign aux_wr = wr && paddr == gpib_ctrl_pkg::OFS_AUX_CMD;
	assign aux = gpib_ctrl_pkg::aux_cmd_t'(pwdata[3:0]);
	assign rd_one = access && !pwrite && paddr == gpib_ctrl_pkg::OFS_INT_STATUS_ONE;
	assign rd_two = access && !pwrite && paddr == gpib_ctrl_pkg::OFS_INT_STATUS_TWO;
	assign acc = q.ah == gpib_ctrl_pkg::A_RDY && asn.dav;
	assign src_done = q.sh == gpib_ctrl_pkg::S_DAV && !asn.ndac;
	assign cmd_v = (acc && asn.atn) || (src_done && q.src_cmd);
	assign cmd_b = (acc ? asn.dio : q.command_data_out_register) & 8'h7F;
	assign cont_on = !q.talker_active_bit && !q.listener_active && (q.cont ||
		(q.auxiliary_register_a.holdoff_on_end_bit && q.auxiliary_register_a.holdoff_on_all_bit));
	assign listen = q.ctl != gpib_ctrl_pkg::C_ACT && (asn.atn || q.listener_active || cont_on);

	always_comb begin
		n = q;
		set1 = '0;
		set2 = '0;
		n.s1 = bus_in;
		n.s2 = q.s1;
		// apb setup: decode and capture read data
		if (setup) begin
			n.slverr = 1'b0;
			n.rdata = '0;
			case (paddr)
				gpib_ctrl_pkg::OFS_AUX_CMD: n.rdata = '0;
				gpib_ctrl_pkg::OFS_CMD_DATA: n.rdata[7:0] = q.data_in_reg;
				gpib_ctrl_pkg::OFS_ADDR_STATUS: n.rdata[5:0] = {q.sys_ctl, asn.atn, q.listener_active,
					q.talker_active_bit, q.ctl == gpib_ctrl_pkg::C_ACT,
					q.ctl == gpib_ctrl_pkg::C_ACT || q.ctl == gpib_ctrl_pkg::C_STBY};
				gpib_ctrl_pkg::OFS_INT_STATUS_ONE: n.rdata[3:0] = q.interrupt_status_one;
				gpib_ctrl_pkg::OFS_INT_STATUS_TWO: n.rdata[1:0] = q.interrupt_status_two;
				gpib_ctrl_pkg::OFS_AUX_A: n.rdata[1:0] = q.auxiliary_register_a;
				gpib_ctrl_pkg::OFS_AUX_B: n.rdata[0] = q.pass_through_en;
				gpib_ctrl_pkg::OFS_MY_ADDR: n.rdata[4:0] = q.my_addr;
				gpib_ctrl_pkg::OFS_PASS_THROUGH: n.rdata[7:0] = q.command_pass_through_register;
				default: n.slverr = 1'b1;
			endcase
		end
		// reading the input byte frees a listener holdoff
		if (access && !pwrite && paddr == gpib_ctrl_pkg::OFS_CMD_DATA) begin
			n.dir_full = 1'b0;
			if (q.listener_active) begin
				n.hold = 1'b0;
			end
		end
		// apb access: writes
		if (wr) begin
			case (paddr)
				gpib_ctrl_pkg::OFS_CMD_DATA: begin
					if (q.ctl == gpib_ctrl_pkg::C_ACT && q.sh == gpib_ctrl_pkg::S_IDLE) begin
						n.command_data_out_register = pwdata[7:0];
						n.sh = gpib_ctrl_pkg::S_NRFD;
						n.src_cmd = 1'b1;
						n.interrupt_status_two.command_output_status = 1'b0;
					end else if (q.talker_active_bit && !asn.atn && q.sh == gpib_ctrl_pkg::S_IDLE) begin
						n.command_data_out_register = pwdata[7:0];
						n.sh = gpib_ctrl_pkg::S_NRFD;
						n.src_cmd = 1'b0;
						n.interrupt_status_one.data_out_status = 1'b0;
					end
				end
				gpib_ctrl_pkg::OFS_AUX_A: n.auxiliary_register_a = pwdata[1:0];
				gpib_ctrl_pkg::OFS_AUX_B: n.pass_through_en = pwdata[0];
				gpib_ctrl_pkg::OFS_MY_ADDR: n.my_addr = pwdata[4:0];
				default: ;
			endcase
		end
		// auxiliary commands
		if (aux_wr) begin
			case (aux)
				gpib_ctrl_pkg::AUX_SET_IFC: begin
					n.sys_ctl = 1'b1;
					n.ifc_drv = 1'b1;
				end
				gpib_ctrl_pkg::AUX_CLR_IFC: n.ifc_drv = 1'b0;
				gpib_ctrl_pkg::AUX_DIS_SC: begin
					n.sys_ctl = 1'b0;
					n.ifc_drv = 1'b0;
					n.ren_drv = 1'b0;
				end
				gpib_ctrl_pkg::AUX_GTS: begin
					if (q.ctl == gpib_ctrl_pkg::C_ACT && q.sh == gpib_ctrl_pkg::S_IDLE) begin
						n.ctl = gpib_ctrl_pkg::C_STBY;
					end
				end
				gpib_ctrl_pkg::AUX_TCA: begin
					if (q.ctl == gpib_ctrl_pkg::C_STBY) begin
						n.ctl = gpib_ctrl_pkg::C_ACT;
						n.take_sync = 1'b0;
						n.sh = gpib_ctrl_pkg::S_IDLE;
						set2.command_output_status = 1'b1;
					end
				end
				gpib_ctrl_pkg::AUX_TCS, gpib_ctrl_pkg::AUX_TCSE: begin
					if (q.ctl == gpib_ctrl_pkg::C_STBY) begin
						n.take_sync = 1'b1;
					end
				end
				gpib_ctrl_pkg::AUX_LCONT: n.cont = 1'b1;
				gpib_ctrl_pkg::AUX_LUNL: begin
					n.cont = 1'b0;
					n.listener_active = 1'b0;
				end
				gpib_ctrl_pkg::AUX_LISTEN: begin
					n.listener_active = 1'b1;
					n.talker_active_bit = 1'b0;
				end
				gpib_ctrl_pkg::AUX_FINISH: n.hold = 1'b0;
				gpib_ctrl_pkg::AUX_SET_REN: n.ren_drv = 1'b1;
				gpib_ctrl_pkg::AUX_CLR_REN: n.ren_drv = 1'b0;
				default: ;
			endcase
		end
		// source handshake for commands and talker data
		unique case (q.sh)
			gpib_ctrl_pkg::S_IDLE: ;
			gpib_ctrl_pkg::S_NRFD: begin
				if (!asn.nrfd) begin
					n.sh = gpib_ctrl_pkg::S_DAV;
				end
			end
			gpib_ctrl_pkg::S_DAV: begin
				if (src_done) begin
					n.sh = gpib_ctrl_pkg::S_IDLE;
					if (!q.src_cmd) begin
						set1.data_out_status = 1'b1;
					end else if ((q.command_data_out_register & 8'h7F) == gpib_ctrl_pkg::CMD_TCT) begin
						n.ctl = gpib_ctrl_pkg::C_IDLE;
					end else begin
						set2.command_output_status = 1'b1;
					end
				end
			end
			default: n.sh = gpib_ctrl_pkg::S_IDLE;
		endcase
		// acceptor handshake for commands and data
		if (!listen) begin
			n.ah = gpib_ctrl_pkg::A_IDLE;
		end else begin
			unique case (q.ah)
				gpib_ctrl_pkg::A_IDLE: n.ah = gpib_ctrl_pkg::A_RDY;
				gpib_ctrl_pkg::A_RDY: begin
					if (acc) begin
						n.ah = gpib_ctrl_pkg::A_ACC;
						n.hold = 1'b0;
						if (!asn.atn) begin
							set1.end_rx = asn.eoi;
							if (q.listener_active) begin
								n.data_in_reg = asn.dio;
								n.dir_full = 1'b1;
								set1.data_in_status = 1'b1;
								n.hold = 1'b1;
							end else begin
								n.hold = q.auxiliary_register_a.holdoff_on_all_bit ||
									(asn.eoi && (q.auxiliary_register_a.holdoff_on_end_bit || q.cont));
							end
						end
					end
				end
				gpib_ctrl_pkg::A_ACC: begin
					if (!asn.dav) begin
						n.ah = q.hold ? gpib_ctrl_pkg::A_HOLD : gpib_ctrl_pkg::A_RDY;
					end
				end
				gpib_ctrl_pkg::A_HOLD: begin
					if (!q.hold) begin
						n.ah = gpib_ctrl_pkg::A_RDY;
					end
				end
			endcase
		end
		// command decode, received or sent by this end
		if (cmd_v) begin
			if (cmd_b[6:5] == gpib_ctrl_pkg::GRP_TALK) begin
				n.talker_active_bit = cmd_b[4:0] == q.my_addr && cmd_b != gpib_ctrl_pkg::CMD_UNT;
				if (cmd_b[4:0] == q.my_addr && cmd_b != gpib_ctrl_pkg::CMD_UNT) begin
					n.listener_active = 1'b0;
					set2.addr_change = 1'b1;
					set1.data_out_status = 1'b1;
				end
			end
			if (cmd_b == gpib_ctrl_pkg::CMD_UNL) begin
				n.listener_active = 1'b0;
			end else if (cmd_b[6:5] == gpib_ctrl_pkg::GRP_LISTEN && cmd_b[4:0] == q.my_addr) begin
				n.listener_active = 1'b1;
				n.talker_active_bit = 1'b0;
				set2.addr_change = 1'b1;
			end
			if (acc && cmd_b == gpib_ctrl_pkg::CMD_TCT) begin
				if (q.pass_through_en) begin
					n.command_pass_through_register = cmd_b;
					set1.pass_through_status = 1'b1;
				end
				if (q.talker_active_bit) begin
					n.ctl = gpib_ctrl_pkg::C_WAIT;
				end
			end
		end
		// controller states
		if (asn.ifc) begin
			n.talker_active_bit = 1'b0;
			n.listener_active = 1'b0;
			// own ifc tail after clear keeps the take armed
			n.ctl = q.ifc_drv || (q.sys_ctl && q.ctl == gpib_ctrl_pkg::C_WAIT) ?
				gpib_ctrl_pkg::C_WAIT : gpib_ctrl_pkg::C_IDLE;
		end else if (q.ctl == gpib_ctrl_pkg::C_WAIT && !asn.atn) begin
			n.ctl = gpib_ctrl_pkg::C_ACT;
			n.take_sync = 1'b0;
			set2.command_output_status = 1'b1;
		end else if (q.ctl == gpib_ctrl_pkg::C_STBY && q.take_sync && q.ah == gpib_ctrl_pkg::A_HOLD) begin
			n.ctl = gpib_ctrl_pkg::C_ACT;
			n.take_sync = 1'b0;
			n.hold = 1'b0;
			set2.command_output_status = 1'b1;
		end
		// read clears only the reported bits; a new event wins
		if (rd_one) begin
			n.interrupt_status_one = gpib_ctrl_pkg::interrupt_status_one_t'(n.interrupt_status_one & ~q.rdata[3:0]);
		end
		if (rd_two) begin
			n.interrupt_status_two = gpib_ctrl_pkg::interrupt_status_two_t'(n.interrupt_status_two & ~q.rdata[1:0]);
		end
		n.interrupt_status_one = gpib_ctrl_pkg::interrupt_status_one_t'(n.interrupt_status_one | set1);
		n.interrupt_status_two = gpib_ctrl_pkg::interrupt_status_two_t'(n.interrupt_status_two | set2);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= gpib_ctrl_pkg::ST_RESET;
		end else begin
			q <= n;
		end
	end

	// pins: open drain, enable drives the line low
	always_comb begin
		bus_out = '0;
		bus_oe = '0;
		bus_oe.atn = q.ctl == gpib_ctrl_pkg::C_ACT;
		bus_oe.ifc = q.sys_ctl && q.ifc_drv;
		bus_oe.ren = q.sys_ctl && q.ren_drv;
		bus_oe.dav = q.sh == gpib_ctrl_pkg::S_DAV;
		bus_oe.nrfd = q.ah == gpib_ctrl_pkg::A_ACC || q.ah == gpib_ctrl_pkg::A_HOLD;
		bus_oe.ndac = q.ah == gpib_ctrl_pkg::A_RDY || q.ah == gpib_ctrl_pkg::A_HOLD;
		bus_oe.dio = q.sh != gpib_ctrl_pkg::S_IDLE ? q.command_data_out_register : 8'h00;
	end
	assign sc_drive = q.sys_ctl;
	assign pready = 1'b1;
	assign prdata = q.rdata;
	assign pslverr = access && q.slverr;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_atn_in_charge: assert property (
		q.ctl == gpib_ctrl_pkg::C_IDLE |=> !bus_oe.atn)
		else $error("atn driven straight from idle");
	a_ifc_drive_dir: assert property (
		aux_wr && aux == gpib_ctrl_pkg::AUX_SET_IFC |=> sc_drive && bus_oe.ifc)
		else $error("set ifc did not turn transceivers to drive");
	a_sc_release: assert property (
		aux_wr && aux == gpib_ctrl_pkg::AUX_DIS_SC |=> !sc_drive && !bus_oe.ifc && !bus_oe.ren)
		else $error("disable system control left drivers on");
	a_take_after_ifc: assert property (
		q.ctl == gpib_ctrl_pkg::C_WAIT && !asn.atn && !asn.ifc |=> bus_oe.atn
		&& q.interrupt_status_two.command_output_status)
		else $error("did not take charge after atn release");
	a_mta_talker: assert property (
		cmd_v && cmd_b == {3'b010, q.my_addr} && !asn.ifc |=> q.talker_active_bit && !q.listener_active)
		else $error("own talk address did not set talker active");
	a_tct_pass: assert property (
		acc && asn.atn && cmd_b == gpib_ctrl_pkg::CMD_TCT && q.pass_through_en
		|=> q.interrupt_status_one.pass_through_status && q.command_pass_through_register == gpib_ctrl_pkg::CMD_TCT)
		else $error("tct not passed through");
	a_tct_to_wait: assert property (
		acc && asn.atn && cmd_b == gpib_ctrl_pkg::CMD_TCT && q.talker_active_bit && !asn.ifc
		|=> q.ctl == gpib_ctrl_pkg::C_WAIT)
		else $error("tct to talker did not arm control take");
	a_gts_standby: assert property (
		aux_wr && aux == gpib_ctrl_pkg::AUX_GTS && q.ctl == gpib_ctrl_pkg::C_ACT && q.sh == gpib_ctrl_pkg::S_IDLE
		&& !asn.ifc |=> !bus_oe.atn && q.ctl == gpib_ctrl_pkg::C_STBY)
		else $error("go to standby failed");
	a_sync_take: assert property (
		q.ctl == gpib_ctrl_pkg::C_STBY && q.take_sync && q.ah == gpib_ctrl_pkg::A_HOLD && !asn.ifc
		|=> bus_oe.atn ##0 q.interrupt_status_two.command_output_status)
		else $error("synchronous take at holdoff failed");
	a_cont_no_data: assert property (
		acc && !asn.atn && !q.listener_active |=> $stable(q.data_in_reg) && !q.dir_full[*1])
		else $error("continuous mode stored data");
	a_pass_idle: assert property (
		src_done && q.src_cmd && (q.command_data_out_register & 8'h7F) == gpib_ctrl_pkg::CMD_TCT && !asn.ifc
		|=> !bus_oe.atn && q.ctl == gpib_ctrl_pkg::C_IDLE)
		else $error("passing control did not release atn");
	c_take_ifc: cover property (q.ctl == gpib_ctrl_pkg::C_WAIT ##1 q.ctl == gpib_ctrl_pkg::C_ACT);
	c_standby_back: cover property (q.ctl == gpib_ctrl_pkg::C_STBY ##[1:200] q.ctl == gpib_ctrl_pkg::C_ACT);
	c_pass_ctl: cover property (q.ctl == gpib_ctrl_pkg::C_ACT ##1 q.ctl == gpib_ctrl_pkg::C_IDLE);
endmodule : gpib_ctrl

/* hw/gpib_ctrl_pkg.sv */
// package: register map, field layouts, commands and state of the gpib controller block
package gpib_ctrl_pkg;
	localparam int APB_AW = 8;
	localparam logic [7:0] OFS_AUX_CMD = 8'h00;
	localparam logic [7:0] OFS_CMD_DATA = 8'h04;
	localparam logic [7:0] OFS_ADDR_STATUS = 8'h08;
	localparam logic [7:0] OFS_INT_STATUS_ONE = 8'h0C;
	localparam logic [7:0] OFS_INT_STATUS_TWO = 8'h10;
	localparam logic [7:0] OFS_AUX_A = 8'h14;
	localparam logic [7:0] OFS_AUX_B = 8'h18;
	localparam logic [7:0] OFS_MY_ADDR = 8'h1C;
	localparam logic [7:0] OFS_PASS_THROUGH = 8'h20;
	localparam logic [7:0] CMD_TCT = 8'h09;
	localparam logic [7:0] CMD_UNL = 8'h3F;
	localparam logic [7:0] CMD_UNT = 8'h5F;
	localparam logic [1:0] GRP_LISTEN = 2'h1;
	localparam logic [1:0] GRP_TALK = 2'h2;
	typedef enum logic [3:0] {
		AUX_NOP = 4'h0, AUX_SET_IFC = 4'h1, AUX_CLR_IFC = 4'h2, AUX_DIS_SC = 4'h3,
		AUX_GTS = 4'h4, AUX_TCA = 4'h5, AUX_TCS = 4'h6, AUX_TCSE = 4'h7,
		AUX_LCONT = 4'h8, AUX_LUNL = 4'h9, AUX_LISTEN = 4'hA, AUX_FINISH = 4'hB,
		AUX_SET_REN = 4'hC, AUX_CLR_REN = 4'hD
	} aux_cmd_t;
	typedef enum logic [1:0] {C_IDLE = 2'b00, C_WAIT = 2'b01, C_ACT = 2'b10, C_STBY = 2'b11} ctl_state_t;
	typedef enum logic [1:0] {S_IDLE = 2'b00, S_NRFD = 2'b01, S_DAV = 2'b10} src_state_t;
	typedef enum logic [1:0] {A_IDLE = 2'b00, A_RDY = 2'b01, A_ACC = 2'b10, A_HOLD = 2'b11} acc_state_t;
	typedef struct packed {
		logic atn; logic ifc; logic ren; logic eoi; logic dav; logic nrfd; logic ndac; logic [7:0] dio;
	} gpib_lines_t;
	typedef struct packed {
		logic end_rx; logic pass_through_status; logic data_out_status; logic data_in_status;
	} interrupt_status_one_t;
	typedef struct packed {
		logic addr_change; logic command_output_status;
	} interrupt_status_two_t;
	typedef struct packed {
		logic holdoff_on_end_bit; logic holdoff_on_all_bit;
	} auxiliary_register_a_t;
	typedef struct packed {
		ctl_state_t ctl; src_state_t sh; acc_state_t ah;
		gpib_lines_t s1; gpib_lines_t s2;
		logic sys_ctl; logic ifc_drv; logic ren_drv;
		logic talker_active_bit; logic listener_active; logic take_sync; logic cont; logic hold;
		logic src_cmd; logic dir_full;
		logic [4:0] my_addr;
		auxiliary_register_a_t auxiliary_register_a;
		logic pass_through_en;
		logic [7:0] command_data_out_register; logic [7:0] data_in_reg;
		logic [7:0] command_pass_through_register;
		interrupt_status_one_t interrupt_status_one;
		interrupt_status_two_t interrupt_status_two;
		logic [31:0] rdata; logic slverr;
	} st_t;
	localparam st_t ST_RESET = '{ctl: C_IDLE, sh: S_IDLE, ah: A_IDLE, s1: '1, s2: '1, default: '0};
endpackage : gpib_ctrl_pkg

/* bench/gpib_bus_model.sv */
// far side model: other bus devices, acceptor and controller-talker
`timescale 1ns/1ps
module gpib_bus_model (
	input wire logic pclk,
	input wire gpib_ctrl_pkg::gpib_lines_t bus,
	output gpib_ctrl_pkg::gpib_lines_t drv
);
	int acc_delay = 1;
	logic src_busy = 1'h0;
	logic [7:0] rx_byte = 8'h00;
	initial begin
		drv = '0;
		drv.ndac = 1'h1;
	end
	// accept every byte the block sources, delay sets prompt or slow
	always begin
		@(posedge pclk);
		if (!src_busy && !bus.dav) begin
			drv.nrfd <= 1'h1;
			rx_byte <= ~bus.dio;
			repeat (acc_delay) @(posedge pclk);
			drv.ndac <= 1'h0;
			while (!bus.dav) @(posedge pclk);
			drv.ndac <= 1'h1;
			drv.nrfd <= 1'h0;
		end
	end
	task automatic set_atn(input logic v);
		@(posedge pclk);
		drv.atn <= v;
		repeat (4) @(posedge pclk);
	endtask : set_atn
	// source handshake: wait ready, hold dav until all accepted
	task automatic send(input logic [7:0] b, input logic eoi_on);
		@(posedge pclk);
		src_busy = 1'h1;
		drv.ndac <= 1'h0;
		drv.dio <= b;
		drv.eoi <= eoi_on;
		do @(posedge pclk); while (!bus.nrfd);
		drv.dav <= 1'h1;
		do @(posedge pclk); while (!bus.ndac);
		drv.dav <= 1'h0;
		drv.eoi <= 1'h0;
		drv.dio <= 8'h00;
		@(posedge pclk);
		src_busy = 1'h0;
		drv.ndac <= 1'h1;
	endtask : send
endmodule : gpib_bus_model

/* bench/testbench.sv */
// testbench for the gpib controller block
`timescale 1ns/1ps
module testbench;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [gpib_ctrl_pkg::APB_AW-1:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready;
	logic pslverr;
	logic err;
	logic sc_drive;
	gpib_ctrl_pkg::gpib_lines_t bus_in;
	gpib_ctrl_pkg::gpib_lines_t bus_out;
	gpib_ctrl_pkg::gpib_lines_t bus_oe;
	gpib_ctrl_pkg::gpib_lines_t drv;
	int n_mismatch = 0;
	int compares = 0;
	int cycles = 0;
	// open-drain wires with pull-ups: low where any party asserts
	assign bus_in = gpib_ctrl_pkg::gpib_lines_t'(~(bus_oe | drv));
	gpib_ctrl dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.bus_in(bus_in),
		.bus_out(bus_out),
		.bus_oe(bus_oe),
		.sc_drive(sc_drive)
	);
	gpib_bus_model far_end (
		.pclk(pclk),
		.bus(bus_in),
		.drv(drv)
	);
	task automatic complete_run();
		if (n_mismatch == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] m = 32'hFFFFFFFF);
		apb(1'h0, a, 32'h0);
		chk(name, exp, rd & m);
	endtask : rdc
	task automatic aux(input gpib_ctrl_pkg::aux_cmd_t c);
		apb(1'h1, gpib_ctrl_pkg::OFS_AUX_CMD, {28'h0, c});
	endtask : aux
	task automatic wait_co(input logic [7:0] a = gpib_ctrl_pkg::OFS_INT_STATUS_TWO, input int b = 0);
		int n;
		n = 0;
		do begin
			apb(1'h0, a, 32'h0);
			n++;
		end while (rd[b] !== 1'h1 && n < 200);
		chk("status_bit", 32'h1, {31'h0, rd[b]});
	endtask : wait_co
	task automatic wait_atn(input logic v);
		int n;
		n = 0;
		while (bus_oe.atn !== v && n < 200) begin
			@(negedge pclk);
			n++;
		end
		chk("atn_drive", {31'h0, v}, {31'h0, bus_oe.atn});
		// line status is seen through the synchroniser
		repeat (3) @(posedge pclk);
	endtask : wait_atn
	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end
	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = '0;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		chk("sc_drive", 32'h0, {31'h0, sc_drive});
		chk("bus_oe", 32'h0, {17'h0, bus_oe});
		chk("bus_out", 32'h0, {17'h0, bus_out});
		presetn <= 1'h1;
		aux(gpib_ctrl_pkg::AUX_DIS_SC);
		rdc("addr_status", gpib_ctrl_pkg::OFS_ADDR_STATUS, 32'h0);
		apb(1'h0, 8'h40, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		chk("unmapped", 32'h0, rd);
		apb(1'h1, gpib_ctrl_pkg::OFS_MY_ADDR, 32'h5);
		apb(1'h1, gpib_ctrl_pkg::OFS_AUX_B, 32'h1);
		rdc("my_addr", gpib_ctrl_pkg::OFS_MY_ADDR, 32'h5);
		rdc("aux_b", gpib_ctrl_pkg::OFS_AUX_B, 32'h1);
		// take control as system controller
		aux(gpib_ctrl_pkg::AUX_SET_IFC);
		@(negedge pclk);
		chk("sc_drive", 32'h1, {31'h0, sc_drive});
		chk("ifc_drive", 32'h1, {31'h0, bus_oe.ifc});
		repeat (10000) @(posedge pclk);
		aux(gpib_ctrl_pkg::AUX_CLR_IFC);
		wait_atn(1'h1);
		wait_co();
		rdc("addr_status", gpib_ctrl_pkg::OFS_ADDR_STATUS, 32'h33);
		// address self as listener, then standby
		apb(1'h1, gpib_ctrl_pkg::OFS_CMD_DATA, 32'h25);
		wait_co();
		chk("rx_byte", 32'h25, {24'h0, far_end.rx_byte});
		rdc("addr_status", gpib_ctrl_pkg::OFS_ADDR_STATUS, 32'h3B);
		aux(gpib_ctrl_pkg::AUX_GTS);
		wait_atn(1'h0);
		rdc("addr_status", gpib_ctrl_pkg::OFS_ADDR_STATUS, 32'h29);
		far_end.send(8'hA5, 1'h1);
		rdc("data_in", gpib_ctrl_pkg::OFS_INT_STATUS_ONE, 32'h1, 32'h1);
		aux(gpib_ctrl_pkg::AUX_TCS);
		wait_atn(1'h1);
		wait_co();
		rdc("data_byte", gpib_ctrl_pkg::OFS_CMD_DATA, 32'hA5);
		// continuous mode, take on end
		aux(gpib_ctrl_pkg::AUX_LUNL);
		aux(gpib_ctrl_pkg::AUX_LCONT);
		aux(gpib_ctrl_pkg::AUX_GTS);
		wait_atn(1'h0);
		aux(gpib_ctrl_pkg::AUX_TCSE);
		far_end.send(8'h3C, 1'h1);
		wait_atn(1'h1);
		wait_co();
		rdc("end_rx", gpib_ctrl_pkg::OFS_INT_STATUS_ONE, 32'h8, 32'h9);
		rdc("addr_status", gpib_ctrl_pkg::OFS_ADDR_STATUS, 32'h33);
		// continuous mode, take after end received
		aux(gpib_ctrl_pkg::AUX_GTS);
		wait_atn(1'h0);
		far_end.send(8'h6B, 1'h1);
		wait_co(gpib_ctrl_pkg::OFS_INT_STATUS_ONE, 3);
		aux(gpib_ctrl_pkg::AUX_TCS);
		wait_atn(1'h1);
		wait_co();
		// pass control away to a slow acceptor
		far_end.acc_delay = 6;
		apb(1'h1, gpib_ctrl_pkg::OFS_CMD_DATA, 32'h47);
		wait_co();
		apb(1'h1, gpib_ctrl_pkg::OFS_CMD_DATA, {24'h0, gpib_ctrl_pkg::CMD_TCT});
		wait_atn(1'h0);
		chk("rx_byte", {24'h0, gpib_ctrl_pkg::CMD_TCT}, {24'h0, far_end.rx_byte});
		rdc("addr_status", gpib_ctrl_pkg::OFS_ADDR_STATUS, 32'h20);
		far_end.acc_delay = 1;
		// receive control back
		far_end.set_atn(1'h1);
		far_end.send(8'h45, 1'h0);
		rdc("addr_status", gpib_ctrl_pkg::OFS_ADDR_STATUS, 32'h34);
		far_end.send(gpib_ctrl_pkg::CMD_TCT, 1'h0);
		rdc("pass_through", gpib_ctrl_pkg::OFS_PASS_THROUGH, {24'h0, gpib_ctrl_pkg::CMD_TCT});
		rdc("pt_status", gpib_ctrl_pkg::OFS_INT_STATUS_ONE, 32'h4, 32'h4);
		far_end.set_atn(1'h0);
		wait_atn(1'h1);
		wait_co();
		rdc("addr_status", gpib_ctrl_pkg::OFS_ADDR_STATUS, 32'h37);
		// talk in standby, take back asynchronously
		apb(1'h1, gpib_ctrl_pkg::OFS_CMD_DATA, 32'h45);
		wait_co();
		aux(gpib_ctrl_pkg::AUX_GTS);
		wait_atn(1'h0);
		wait_co(gpib_ctrl_pkg::OFS_INT_STATUS_ONE, 1);
		apb(1'h1, gpib_ctrl_pkg::OFS_CMD_DATA, 32'h5A);
		wait_co(gpib_ctrl_pkg::OFS_INT_STATUS_ONE, 1);
		chk("rx_byte", 32'h5A, {24'h0, far_end.rx_byte});
		aux(gpib_ctrl_pkg::AUX_TCA);
		wait_atn(1'h1);
		wait_co();
		rdc("addr_status", gpib_ctrl_pkg::OFS_ADDR_STATUS, 32'h37);
		// ren drive, leave system control, then reset while driving
		aux(gpib_ctrl_pkg::AUX_SET_REN);
		@(negedge pclk);
		chk("ren_drive", 32'h1, {31'h0, bus_oe.ren});
		aux(gpib_ctrl_pkg::AUX_DIS_SC);
		@(negedge pclk);
		chk("sc_drive", 32'h0, {31'h0, sc_drive});
		chk("ren_drive", 32'h0, {31'h0, bus_oe.ren});
		aux(gpib_ctrl_pkg::AUX_SET_IFC);
		@(negedge pclk);
		chk("sc_drive", 32'h1, {31'h0, sc_drive});
		@(posedge pclk);
		presetn <= 1'h0;
		@(negedge pclk);
		chk("sc_drive", 32'h0, {31'h0, sc_drive});
		complete_run();
	end
endmodule : testbench
